// ==== hdl/ufi_core.sv ====
`timescale 1ns/1ps
// Summary of operation
// - With FIFOs on, receive-data-available rises when the receive fill reaches the receiver trigger level.
// - A pending receive-data-available interrupt reads as code 0100 in identity bits 3 to 0.
// - Line status bit 0 is set whenever received data is available.
// - A receive buffer read returns the single held character without FIFOs, or pops the oldest entry with them.
// - Receive-data-available clears on a buffer read without FIFOs, or when the fill drops below the trigger with them.
// - The FIFO control register holds a transmit empty trigger that sets the empty interrupt level in programmable mode.
// - Enable bit 7 turns programmable empty mode on, and while it is 0 the trigger acts as 00, meaning empty.
// - A pending transmit-holding-empty interrupt reads as its own identity code, 0010.
// - With FIFOs on, each holding register write pushes one character into the transmit FIFO, unless the FIFO is full.
// - Transmit-holding-empty clears on a holding write without FIFOs, or when the fill rises above the trigger with them.
// - Receive-data-available is asserted only while its enable bit is set.
// - Transmit-holding-empty is asserted only while its enable bit is set.
// - A FIFO control write can enable both FIFOs and reset their contents and pointers.
// - The transmit empty trigger sits in control bits 5 to 4 and selects empty, two, quarter and half full.
// - In programmable empty mode line status bit 5 shows transmit FIFO full rather than empty.
// - With FIFOs off through control bit 0, programmable mode is inactive and bit 5 and the interrupt mean empty.
module ufi_core #(
  parameter int DEPTH = 16
) (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic [7:0] rx_char,
  input  wire logic       rx_char_valid,
  output logic            rx_char_ready,
  output logic      [7:0] tx_char,
  output logic            tx_char_valid,
  input  wire logic       tx_char_ready,
  output logic            irq
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
  localparam logic [CW-1:0] ONE_C   = CW'(1);

  logic [7:0]          ier_r;
  logic [7:0]          fcr_r;
  logic [7:0]          rx_mem [DEPTH];
  logic [7:0]          tx_mem [DEPTH];
  logic [AW-1:0]       rx_wp_r;
  logic [AW-1:0]       rx_rp_r;
  logic [CW-1:0]       rx_cnt_r;
  logic [AW-1:0]       tx_wp_r;
  logic [AW-1:0]       tx_rp_r;
  logic [CW-1:0]       tx_cnt_r;
  logic [ufi_pkg::EVT_W-1:0] evt_stat_r;
  logic [ufi_pkg::EVT_W-1:0] evt_en_r;
  logic                rx_pend_d_r;
  logic                tx_pend_d_r;
  logic [7:0]          rdata_nxt;

  logic                fifo_en;
  logic                prog_mode;
  logic [CW-1:0]       cap;
  logic [CW-1:0]       rx_lvl;
  logic [CW-1:0]       tx_lvl;
  logic                rx_cond;
  logic                tx_cond;
  logic                rx_pend;
  logic                tx_pend;
  logic                rx_full;
  logic                tx_full;
  logic                rx_push;
  logic                rx_pop;
  logic                tx_push;
  logic                tx_pop;
  logic                fcr_wr;
  logic                en_flip;
  logic                rx_clr;
  logic                tx_clr;
  logic [3:0]          iir_code;
  logic [ufi_pkg::EVT_W-1:0] evt_set;

  // Receiver trigger: one entry, quarter, half, two short of full.
  function automatic logic [CW-1:0] rx_trig_level(input logic [1:0] code);
    logic [CW-1:0] lvl;
    lvl = DEPTH_C - CW'(2);
    if (code == ufi_pkg::TRIG_C0) begin
      lvl = ONE_C;
    end else if (code == ufi_pkg::TRIG_C1) begin
      lvl = DEPTH_C >> 2;
    end else if (code == ufi_pkg::TRIG_C2) begin
      lvl = DEPTH_C >> 1;
    end
    return lvl;
  endfunction : rx_trig_level

  // Transmit empty trigger: empty, two entries, quarter, half full.
  function automatic logic [CW-1:0] tx_trig_level(input logic [1:0] code);
    logic [CW-1:0] lvl;
    lvl = DEPTH_C >> 1;
    if (code == ufi_pkg::TRIG_C0) begin
      lvl = '0;
    end else if (code == ufi_pkg::TRIG_C1) begin
      lvl = CW'(2);
    end else if (code == ufi_pkg::TRIG_C2) begin
      lvl = DEPTH_C >> 2;
    end
    return lvl;
  endfunction : tx_trig_level

  assign fifo_en   = fcr_r[ufi_pkg::FCR_FIFO_EN];
  // Programmable mode needs both the enable bit and the FIFOs.
  assign prog_mode = fifo_en & ier_r[ufi_pkg::IER_PROG];
  // Without FIFOs each side behaves as a single holding register.
  assign cap       = fifo_en ? DEPTH_C : ONE_C;
  assign rx_lvl    = rx_trig_level(fcr_r[ufi_pkg::FCR_RT_LO +: 2]);
  // A cleared mode bit forces the empty setting over the field.
  assign tx_lvl    = prog_mode ?
                     tx_trig_level(fcr_r[ufi_pkg::FCR_TET_LO +: 2]) :
                     '0;

  assign rx_full = (rx_cnt_r >= cap);
  assign tx_full = (tx_cnt_r >= cap);

  assign rx_cond = fifo_en ? (rx_cnt_r >= rx_lvl) : (rx_cnt_r != '0);
  assign tx_cond = (tx_cnt_r <= tx_lvl);
  assign rx_pend = rx_cond & ier_r[ufi_pkg::IER_RX_AVAIL];
  assign tx_pend = tx_cond & ier_r[ufi_pkg::IER_TX_EMPTY];

  // Receive data outranks transmit empty in the identity register.
  always_comb begin
    if (rx_pend) begin
      iir_code = ufi_pkg::IIR_RX_AVAIL;
    end else if (tx_pend) begin
      iir_code = ufi_pkg::IIR_TX_EMPTY;
    end else begin
      iir_code = ufi_pkg::IIR_NONE;
    end
  end

  assign fcr_wr  = reg_wr & (reg_addr == ufi_pkg::ADDR_IIR_FCR);
  // Toggling the FIFO enable empties both sides, since capacity changes.
  assign en_flip = fcr_wr & (reg_wdata[ufi_pkg::FCR_FIFO_EN] != fifo_en);
  assign rx_clr  = fcr_wr & (reg_wdata[ufi_pkg::FCR_RX_RST] | en_flip);
  assign tx_clr  = fcr_wr & (reg_wdata[ufi_pkg::FCR_TX_RST] | en_flip);

  assign rx_char_ready = ~rx_full;
  assign rx_push = rx_char_valid & ~rx_full & ~rx_clr;
  assign rx_pop  = reg_rd & (reg_addr == ufi_pkg::ADDR_DATA) &
                   (rx_cnt_r != '0) & ~rx_clr;
  assign tx_push = reg_wr & (reg_addr == ufi_pkg::ADDR_DATA) &
                   ~tx_full & ~tx_clr;
  assign tx_char_valid = (tx_cnt_r != '0);
  assign tx_pop  = tx_char_valid & tx_char_ready & ~tx_clr;
  assign tx_char = tx_mem[tx_rp_r];

  assign evt_set[ufi_pkg::EVT_RX]  = rx_pend & ~rx_pend_d_r;
  assign evt_set[ufi_pkg::EVT_TX]  = tx_pend & ~tx_pend_d_r;
  assign evt_set[ufi_pkg::EVT_OVR] = rx_char_valid & rx_full;
  assign irq = |(evt_stat_r & evt_en_r);

  // Control registers.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ier_r <= ufi_pkg::IER_RST;
      fcr_r <= ufi_pkg::FCR_RST;
    end else if (ce) begin
      if (reg_wr && reg_addr == ufi_pkg::ADDR_IER) begin
        ier_r <= reg_wdata;
      end
      // Reset bits are self-clearing actions and are not stored.
      if (fcr_wr) begin
        fcr_r <= reg_wdata & 8'hF1;
      end
    end
  end

  // Receive storage.
  always_ff @(posedge core_clk) begin
    if (ce && rx_push) begin
      rx_mem[rx_wp_r] <= rx_char;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_wp_r  <= '0;
      rx_rp_r  <= '0;
      rx_cnt_r <= '0;
    end else if (ce) begin
      if (rx_clr) begin
        rx_wp_r  <= '0;
        rx_rp_r  <= '0;
        rx_cnt_r <= '0;
      end else begin
        if (rx_push) begin
          rx_wp_r <= fifo_en ? rx_wp_r + AW'(1) : '0;
        end
        if (rx_pop) begin
          rx_rp_r <= fifo_en ? rx_rp_r + AW'(1) : '0;
        end
        if (rx_push && !rx_pop) begin
          rx_cnt_r <= rx_cnt_r + ONE_C;
        end else if (rx_pop && !rx_push) begin
          rx_cnt_r <= rx_cnt_r - ONE_C;
        end
      end
    end
  end

  // Transmit storage.
  always_ff @(posedge core_clk) begin
    if (ce && tx_push) begin
      tx_mem[tx_wp_r] <= reg_wdata;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_wp_r  <= '0;
      tx_rp_r  <= '0;
      tx_cnt_r <= '0;
    end else if (ce) begin
      if (tx_clr) begin
        tx_wp_r  <= '0;
        tx_rp_r  <= '0;
        tx_cnt_r <= '0;
      end else begin
        if (tx_push) begin
          tx_wp_r <= fifo_en ? tx_wp_r + AW'(1) : '0;
        end
        if (tx_pop) begin
          tx_rp_r <= fifo_en ? tx_rp_r + AW'(1) : '0;
        end
        if (tx_push && !tx_pop) begin
          tx_cnt_r <= tx_cnt_r + ONE_C;
        end else if (tx_pop && !tx_push) begin
          tx_cnt_r <= tx_cnt_r - ONE_C;
        end
      end
    end
  end

  // Sticky events; a new event in the clearing cycle survives.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      evt_stat_r  <= '0;
      evt_en_r    <= ufi_pkg::EVT_EN_RST;
      rx_pend_d_r <= 1'b0;
      tx_pend_d_r <= 1'b0;
    end else if (ce) begin
      rx_pend_d_r <= rx_pend;
      tx_pend_d_r <= tx_pend;
      if (reg_wr && reg_addr == ufi_pkg::ADDR_EVT_CLR) begin
        evt_stat_r <= (evt_stat_r & ~reg_wdata[ufi_pkg::EVT_W-1:0]) |
                      evt_set;
      end else begin
        evt_stat_r <= evt_stat_r | evt_set;
      end
      if (reg_wr && reg_addr == ufi_pkg::ADDR_EVT_EN) begin
        evt_en_r <= reg_wdata[ufi_pkg::EVT_W-1:0];
      end
    end
  end

  // Read multiplexer, registered for the one-cycle read latency.
  always_comb begin
    rdata_nxt = 8'h00;
    if (reg_addr == ufi_pkg::ADDR_DATA) begin
      rdata_nxt = (rx_cnt_r != '0) ? rx_mem[rx_rp_r] : 8'h00;
    end else if (reg_addr == ufi_pkg::ADDR_IER) begin
      rdata_nxt = ier_r;
    end else if (reg_addr == ufi_pkg::ADDR_IIR_FCR) begin
      rdata_nxt = {fifo_en ? ufi_pkg::IIR_FIFO_ON : 2'h0, 2'h0,
                   iir_code};
    end else if (reg_addr == ufi_pkg::ADDR_LSR) begin
      rdata_nxt[ufi_pkg::LSR_DATA_READY] = (rx_cnt_r != '0);
      // Full in programmable mode lets software fill by polling.
      rdata_nxt[ufi_pkg::LSR_TX_HOLD] = prog_mode ? tx_full :
                                        (tx_cnt_r == '0);
      rdata_nxt[ufi_pkg::LSR_TX_IDLE] = (tx_cnt_r == '0);
    end else if (reg_addr == ufi_pkg::ADDR_EVT_STAT) begin
      rdata_nxt = {{(8-ufi_pkg::EVT_W){1'b0}}, evt_stat_r};
    end else if (reg_addr == ufi_pkg::ADDR_EVT_EN) begin
      rdata_nxt = {{(8-ufi_pkg::EVT_W){1'b0}}, evt_en_r};
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (ce) begin
      reg_rdata <= reg_rd ? rdata_nxt : 8'h00;
    end
  end

endmodule : ufi_core

// ==== hdl/ufi_pkg.sv ====
package ufi_pkg;

  // Register indices on the plain register port.
  localparam logic [3:0] ADDR_DATA     = 4'h0;
  localparam logic [3:0] ADDR_IER      = 4'h1;
  localparam logic [3:0] ADDR_IIR_FCR  = 4'h2;
  localparam logic [3:0] ADDR_LSR      = 4'h5;
  localparam logic [3:0] ADDR_EVT_STAT = 4'h8;
  localparam logic [3:0] ADDR_EVT_CLR  = 4'h9;
  localparam logic [3:0] ADDR_EVT_EN   = 4'hA;

  // Interrupt enable register fields.
  localparam int IER_RX_AVAIL = 0;
  localparam int IER_TX_EMPTY = 1;
  localparam int IER_PROG     = 7;

  // FIFO control register fields.
  localparam int FCR_FIFO_EN = 0;
  localparam int FCR_RX_RST  = 1;
  localparam int FCR_TX_RST  = 2;
  localparam int FCR_TET_LO  = 4;
  localparam int FCR_RT_LO   = 6;

  // Line status register fields.
  localparam int LSR_DATA_READY = 0;
  localparam int LSR_TX_HOLD    = 5;
  localparam int LSR_TX_IDLE    = 6;

  // Interrupt identity codes and the FIFO-on marker in bits 7 to 6.
  localparam logic [3:0] IIR_NONE     = 4'h1;
  localparam logic [3:0] IIR_RX_AVAIL = 4'h4;
  localparam logic [3:0] IIR_TX_EMPTY = 4'h2;
  localparam logic [1:0] IIR_FIFO_ON  = 2'h3;

  // Sticky event bits.
  localparam int EVT_W   = 3;
  localparam int EVT_RX  = 0;
  localparam int EVT_TX  = 1;
  localparam int EVT_OVR = 2;

  // Reset values.
  localparam logic [7:0]       IER_RST    = 8'h00;
  localparam logic [7:0]       FCR_RST    = 8'h00;
  localparam logic [EVT_W-1:0] EVT_EN_RST = 3'h0;

  // Trigger field codes.
  localparam logic [1:0] TRIG_C0 = 2'h0;
  localparam logic [1:0] TRIG_C1 = 2'h1;
  localparam logic [1:0] TRIG_C2 = 2'h2;

endpackage : ufi_pkg

// ==== tb/ufi_assertions.sv ====
`timescale 1ns/1ps
module ufi_assertions #(
  parameter int DEPTH = 16
) (
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic       ce,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       rx_char_valid,
  input wire logic       rx_char_ready,
  input wire logic [7:0] tx_char,
  input wire logic       tx_char_valid,
  input wire logic       tx_char_ready,
  input wire logic       irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  rdata_idle_a: assert property (ce && !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data left standing");
  iir_code_a: assert property (ce && reg_rd &&
    reg_addr == ufi_pkg::ADDR_IIR_FCR |=> reg_rdata[5:0] inside
    {6'h01, 6'h02, 6'h04}) else $error("bad identity code");
  iir_fifo_a: assert property (ce && reg_wr && reg_wdata[0] &&
    reg_addr == ufi_pkg::ADDR_IIR_FCR ##1 ce && reg_rd &&
    reg_addr == ufi_pkg::ADDR_IIR_FCR |=> reg_rdata[7:6] == 2'h3)
    else $error("fifo marker missing");
  lsr_ready_a: assert property (ce && rx_char_valid && rx_char_ready &&
    !reg_rd && !reg_wr ##1 ce && reg_rd && reg_addr == ufi_pkg::ADDR_LSR
    |=> reg_rdata[0]) else $error("data ready not set");
  irq_mask_a: assert property (ce && reg_rd &&
    reg_addr == ufi_pkg::ADDR_EVT_EN ##1 reg_rdata[2:0] == 3'h0 |-> !irq)
    else $error("masked interrupt raised");
  fifo_reset_a: assert property (ce && reg_wr && reg_wdata[2:1] == 2'h3
    && reg_addr == ufi_pkg::ADDR_IIR_FCR |=> rx_char_ready && !tx_char_valid)
    else $error("fifo reset failed");
  tx_push_a: assert property (ce && reg_wr && !tx_char_valid &&
    reg_addr == ufi_pkg::ADDR_DATA |=> tx_char_valid &&
    tx_char == $past(reg_wdata)) else $error("write not queued");
  tx_hold_a: assert property (tx_char_valid && !tx_char_ready && !reg_wr
    |=> tx_char_valid && $stable(tx_char)) else $error("tx head moved");
  ce_freeze_a: assert property (!ce |=> $stable(reg_rdata) &&
    $stable(irq) && $stable(tx_char_valid) && $stable(rx_char_ready))
    else $error("state moved with enable low");
endmodule : ufi_assertions

bind ufi_core ufi_assertions #(.DEPTH(DEPTH)) ufi_assertions_inst (
  .core_clk, .rst, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .rx_char_valid, .rx_char_ready, .tx_char,
  .tx_char_valid, .tx_char_ready, .irq);

// ==== tb/ufi_peer.sv ====
`timescale 1ns/1ps
module ufi_peer (
  input wire logic       core_clk,
  input wire logic       stall,
  output logic     [7:0] rx_char,
  output logic           rx_char_valid,
  input wire logic       rx_char_ready,
  output logic           tx_char_ready
);
  initial begin
    rx_char = 8'h00;
    rx_char_valid = 1'b0;
    tx_char_ready = 1'b0;
  end
  // Random acceptance makes the transmitter both prompt and slow.
  always @(posedge core_clk) tx_char_ready <= !stall && ($urandom % 2 == 0);
  task automatic send(input logic [7:0] ch, input int hold, output bit ok);
    int n;
    bit r;
    n = 0;
    rx_char <= ch;
    rx_char_valid <= 1'b1;
    do begin
      @(negedge core_clk);
      r = rx_char_ready;
      n++;
      @(posedge core_clk);
    end while (!r && n < hold);
    ok = r;
    // Released data is inverted so that a stale sample is caught.
    rx_char <= ~ch;
    rx_char_valid <= 1'b0;
  endtask : send
endmodule : ufi_peer

// ==== tb/ufi_core_test.sv ====
`timescale 1ns/1ps
module ufi_core_test;
  localparam int DEPTH = 16;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic        stall = 1'b1;
  logic        rd_p = 1'b0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic [7:0]  reg_rdata, rx_char, tx_char, c, c0;
  logic        rx_char_valid, rx_char_ready, tx_char_valid, tx_char_ready;
  logic        irq;
  logic [15:0] rq[$];
  logic [15:0] e;
  logic [7:0]  tq[$];
  int          fail_count = 0;
  int          check_count = 0;
  int          i, k, lv;
  bit          ok;

  ufi_core #(.DEPTH(DEPTH)) ufi_core_inst (
    .core_clk, .rst, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .rx_char, .rx_char_valid, .rx_char_ready, .tx_char,
    .tx_char_valid, .tx_char_ready, .irq);
  ufi_peer ufi_peer_inst (
    .core_clk, .stall, .rx_char, .rx_char_valid, .rx_char_ready,
    .tx_char_ready);

  always #12.5 core_clk = ~core_clk;

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %0t seen %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict;
    $display("checks %0d errors %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    @(posedge core_clk);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] m, x);
    rq.push_back({m, x});
    reg_addr <= a;
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask : rd

  task automatic idle;
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge core_clk);
  endtask : idle

  // Read data is judged one edge after its strobe, in issue order.
  always @(posedge core_clk) begin
    if (rd_p) begin
      e = rq.pop_front();
      check(reg_rdata & e[15:8], e[7:0]);
    end
    if (tx_char_valid && tx_char_ready) check(tx_char, tq.pop_front());
    rd_p <= reg_rd;
  end

  initial begin
    i = $urandom(8360);
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    rd(ufi_pkg::ADDR_IER, 8'hFF, 8'h00);
    rd(ufi_pkg::ADDR_EVT_EN, 8'hFF, 8'h00);
    rd(ufi_pkg::ADDR_IIR_FCR, 8'hFF, 8'h01);
    wr(ufi_pkg::ADDR_IER, 8'h01);
    idle;
    c0 = 8'($urandom);
    ufi_peer_inst.send(c0, 20, ok);
    check(8'(ok), 8'h01);
    rd(ufi_pkg::ADDR_LSR, 8'h01, 8'h01);
    rd(ufi_pkg::ADDR_IIR_FCR, 8'hFF, 8'h04);
    wr(ufi_pkg::ADDR_EVT_EN, 8'h07);
    rd(ufi_pkg::ADDR_DATA, 8'hFF, c0);
    rd(ufi_pkg::ADDR_IIR_FCR, 8'hFF, 8'h01);
    idle;
    check(8'(irq), 8'h01);
    wr(ufi_pkg::ADDR_EVT_CLR, 8'h07);
    idle;
    check(8'(irq), 8'h00);
    ufi_peer_inst.send(c0, 20, ok);
    check(8'(ok), 8'h01);
    idle;
    ufi_peer_inst.send(~c0, 3, ok);
    check(8'(ok), 8'h00);
    rd(ufi_pkg::ADDR_EVT_STAT, 8'h04, 8'h04);
    rd(ufi_pkg::ADDR_DATA, 8'hFF, c0);
    wr(ufi_pkg::ADDR_EVT_EN, 8'h00);
    for (k = 0; k < 4; k++) begin
      lv = (k == 0) ? 1 : (k == 1) ? DEPTH / 4 :
           (k == 2) ? DEPTH / 2 : DEPTH - 2;
      wr(ufi_pkg::ADDR_IIR_FCR, {k[1:0], 6'h07});
      for (i = 0; i < lv; i++) begin
        rd(ufi_pkg::ADDR_IIR_FCR, 8'hFF, 8'hC1);
        idle;
        c = 8'($urandom);
        if (i == 0) c0 = c;
        ufi_peer_inst.send(c, 20, ok);
        check(8'(ok), 8'h01);
      end
      rd(ufi_pkg::ADDR_IIR_FCR, 8'hFF, 8'hC4);
      rd(ufi_pkg::ADDR_DATA, 8'hFF, c0);
      rd(ufi_pkg::ADDR_IIR_FCR, 8'hFF, 8'hC1);
    end
    wr(ufi_pkg::ADDR_IER, 8'h82);
    for (k = 0; k < 4; k++) begin
      lv = (k == 0) ? 0 : (k == 1) ? 2 : (k == 2) ? DEPTH / 4 : DEPTH / 2;
      wr(ufi_pkg::ADDR_IIR_FCR, {2'h0, k[1:0], 4'h7});
      for (i = 0; i <= lv; i++) begin
        rd(ufi_pkg::ADDR_IIR_FCR, 8'hFF, 8'hC2);
        wr(ufi_pkg::ADDR_DATA, 8'(i));
      end
      rd(ufi_pkg::ADDR_IIR_FCR, 8'hFF, 8'hC1);
    end
    rd(ufi_pkg::ADDR_LSR, 8'h20, 8'h00);
    repeat (DEPTH - DEPTH / 2 - 1) wr(ufi_pkg::ADDR_DATA, 8'h00);
    rd(ufi_pkg::ADDR_LSR, 8'h20, 8'h20);
    wr(ufi_pkg::ADDR_IER, 8'h02);
    wr(ufi_pkg::ADDR_IIR_FCR, 8'h37);
    rd(ufi_pkg::ADDR_IIR_FCR, 8'hFF, 8'hC2);
    for (i = 0; i < 3; i++) begin
      c = 8'($urandom);
      tq.push_back(c);
      wr(ufi_pkg::ADDR_DATA, c);
    end
    rd(ufi_pkg::ADDR_IIR_FCR, 8'hFF, 8'hC1);
    idle;
    stall <= 1'b0;
    for (i = 0; i < 200 && tq.size() > 0; i++) @(posedge core_clk);
    check(8'(tq.size()), 8'h00);
    // A transmitter that never drained is a hang, so stop here.
    if (tq.size() > 0) give_verdict;
    rd(ufi_pkg::ADDR_LSR, 8'h60, 8'h60);
    rd(ufi_pkg::ADDR_IIR_FCR, 8'hFF, 8'hC2);
    stall <= 1'b1;
    wr(ufi_pkg::ADDR_IER, 8'h80);
    rd(ufi_pkg::ADDR_IIR_FCR, 8'hFF, 8'hC1);
    wr(ufi_pkg::ADDR_IER, 8'h82);
    wr(ufi_pkg::ADDR_IIR_FCR, 8'h30);
    wr(ufi_pkg::ADDR_DATA, 8'h5A);
    rd(ufi_pkg::ADDR_LSR, 8'h20, 8'h00);
    rd(ufi_pkg::ADDR_IIR_FCR, 8'hFF, 8'h01);
    // A write with the clock enable low must not be taken.
    ce <= 1'b0;
    wr(ufi_pkg::ADDR_IER, 8'h00);
    ce <= 1'b1;
    rd(ufi_pkg::ADDR_IER, 8'hFF, 8'h82);
    idle;
    idle;
    give_verdict;
  end
endmodule : ufi_core_test
